/* include/prd_defines.svh */
`ifndef PRD_DEFINES_SVH
`define PRD_DEFINES_SVH

////////////////////////////////////////////////////////////
// offsets common to every page
`define PRD_OFS_CMD          4'h0
// page 0 offsets (write side name, read side shares)
`define PRD_OFS_RING_FIRST   4'h1
`define PRD_OFS_RING_LAST    4'h2
`define PRD_OFS_BOUNDARY     4'h3
`define PRD_OFS_TX_PAGE      4'h4
`define PRD_OFS_TX_LEN_LO    4'h5
`define PRD_OFS_TX_LEN_HI    4'h6
`define PRD_OFS_EVENTS       4'h7
`define PRD_OFS_HDMA_LO      4'h8
`define PRD_OFS_HDMA_HI      4'h9
`define PRD_OFS_HLEN_LO      4'hA
`define PRD_OFS_HLEN_HI      4'hB
`define PRD_OFS_RX_SETUP     4'hC
`define PRD_OFS_TX_SETUP     4'hD
`define PRD_OFS_BUS_SETUP    4'hE
`define PRD_OFS_MASK         4'hF
// page 1 offsets
`define PRD_OFS_STATION_BASE 4'h1
`define PRD_OFS_STATION_LAST 4'h6
`define PRD_OFS_RX_WR_PAGE   4'h7
`define PRD_OFS_GROUP_BASE   4'h8
// page 2 offsets
`define PRD_OFS_HOST_NEXT    4'h3
`define PRD_OFS_NET_NEXT     4'h5
`define PRD_OFS_ACNT_HI      4'h6
`define PRD_OFS_ACNT_LO      4'h7

////////////////////////////////////////////////////////////
// command_control bit positions
`define PRD_CMD_STOP         0
`define PRD_CMD_TXP          2
`define PRD_CMD_DMA_TOP      5
`define PRD_CMD_PAGE_LO      6
`define PRD_CMD_PAGE_HI      7

////////////////////////////////////////////////////////////
// reset and fill values
`define PRD_CMD_RESET        8'h01
`define PRD_CFG_RESET        8'h00
`define PRD_RESERVED_READ    8'h00

`endif

/* include/prd_pkg.sv */
package prd_pkg;

    // page chosen by the two page-select bits
    typedef enum logic [1:0] {
        PRD_PG_WORK   = 2'h0,
        PRD_PG_INIT   = 2'h1,
        PRD_PG_DIAG   = 2'h2,
        PRD_PG_LOCKED = 2'h3
    } prd_page_t;

    // target of a write that lands in logic held elsewhere
    typedef enum logic [2:0] {
        PRD_EW_NONE      = 3'h0,
        PRD_EW_EVENTS    = 3'h1,
        PRD_EW_LDMA_LO   = 3'h3,
        PRD_EW_LDMA_HI   = 3'h2,
        PRD_EW_HOST_NEXT = 3'h6,
        PRD_EW_NET_NEXT  = 3'h7,
        PRD_EW_ACNT_HI   = 3'h5,
        PRD_EW_ACNT_LO   = 3'h4
    } prd_ext_sel_t;

    // configuration bytes held by this block
    typedef struct packed {
        logic [7:0]      ring_first;
        logic [7:0]      ring_last;
        logic [7:0]      boundary;
        logic [7:0]      tx_page;
        logic [15:0]     tx_len;
        logic [15:0]     hdma_start;
        logic [15:0]     hdma_len;
        logic [7:0]      rx_setup;
        logic [7:0]      tx_setup;
        logic [7:0]      bus_setup;
        logic [7:0]      event_mask;
        logic [5:0][7:0] station_addr;
        logic [7:0]      rx_write_page;
        logic [7:0][7:0] group_filter;
    } prd_cfg_t;

    // live values owned by other logic, read only here
    typedef struct packed {
        logic [15:0] ldma_now;
        logic [7:0]  tx_result;
        logic [7:0]  collisions;
        logic [7:0]  fifo_peek;
        logic [7:0]  event_flags;
        logic [15:0] hdma_now;
        logic [7:0]  rx_result;
        logic [7:0]  align_tally;
        logic [7:0]  crc_tally;
        logic [7:0]  missed_tally;
        logic [7:0]  host_next;
        logic [7:0]  net_next;
        logic [15:0] acnt;
    } prd_stat_t;

    // write passed on to its owner
    typedef struct packed {
        prd_ext_sel_t sel;
        logic [7:0]   data;
    } prd_ext_wr_t;

    // whole state of the decoder
    typedef struct packed {
        logic [7:0]  cmd;
        prd_cfg_t    cfg;
        logic [7:0]  rd_data;
        logic        rd_valid;
        prd_ext_wr_t ext;
        logic        fifo_rd;
    } prd_state_t;

endpackage

/* rtl/prd_decoder.sv */
// Summary of operation
// - every register is one full byte
// - page bits in command choose page
// - four select inputs pick one of sixteen
// - page zero: reads and writes differ, except boundary at offset 3
// - page one: station, write page, group filter
// - busy registers sit together in page zero
// - command at offset zero in every page
// - page, stop, dma top bits always writable
`include "prd_defines.svh"

module prd_decoder (
    input  wire logic                   clk,                    // system clock
    input  wire logic                   rst,                    // sync reset, high
    input  wire logic [3:0]             register_select_inputs, // register offset
    input  wire logic                   host_rd,                // read strobe
    input  wire logic                   host_wr,                // write strobe
    input  wire logic [7:0]             host_wdata,             // write byte
    input  wire prd_pkg::prd_stat_t     stat,                   // live status values
    input  wire logic                   txp_done,               // transmit ended pulse
    output logic [7:0]                  host_rdata,             // read byte
    output logic                        host_rdata_valid,       // read byte ready
    output logic [7:0]                  command_control,        // command byte
    output prd_pkg::prd_page_t          page,                   // current page
    output prd_pkg::prd_cfg_t           cfg,                    // configuration
    output prd_pkg::prd_ext_wr_t        ext_wr,                 // passed-on write
    output logic                        fifo_peek_rd            // fifo port read pulse
);

    ////////////////////////////////////////////////////////////
    // state

    prd_pkg::prd_state_t s_q;          // registered state
    prd_pkg::prd_state_t s_d;          // next state
    prd_pkg::prd_page_t  pg;           // decoded page
    logic [3:0]          ofs;          // decoded offset

    ////////////////////////////////////////////////////////////
    // page from command byte
    function automatic prd_pkg::prd_page_t page_of(
        input logic [7:0] c
    );
        page_of = prd_pkg::prd_page_t'({c[`PRD_CMD_PAGE_HI],
                                        c[`PRD_CMD_PAGE_LO]});
    endfunction

    ////////////////////////////////////////////////////////////
    // read side of page 0
    function automatic logic [7:0] read_work(
        input logic [3:0]         o,
        input prd_pkg::prd_cfg_t  c,
        input prd_pkg::prd_stat_t st
    );
        case (o)
            `PRD_OFS_RING_FIRST: read_work = st.ldma_now[7:0];
            `PRD_OFS_RING_LAST:  read_work = st.ldma_now[15:8];
            `PRD_OFS_BOUNDARY:   read_work = c.boundary;
            `PRD_OFS_TX_PAGE:    read_work = st.tx_result;
            `PRD_OFS_TX_LEN_LO:  read_work = st.collisions;
            `PRD_OFS_TX_LEN_HI:  read_work = st.fifo_peek;
            `PRD_OFS_EVENTS:     read_work = st.event_flags;
            `PRD_OFS_HDMA_LO:    read_work = st.hdma_now[7:0];
            `PRD_OFS_HDMA_HI:    read_work = st.hdma_now[15:8];
            `PRD_OFS_RX_SETUP:   read_work = st.rx_result;
            `PRD_OFS_TX_SETUP:   read_work = st.align_tally;
            `PRD_OFS_BUS_SETUP:  read_work = st.crc_tally;
            `PRD_OFS_MASK:       read_work = st.missed_tally;
            default:             read_work = `PRD_RESERVED_READ;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////
    // read side of page 1
    function automatic logic [7:0] read_init(
        input logic [3:0]        o,
        input prd_pkg::prd_cfg_t c
    );
        logic [2:0] si;  // station byte index
        logic [2:0] gi;  // group byte index
        si = 3'(o - `PRD_OFS_STATION_BASE);
        gi = o[2:0];
        if (o >= `PRD_OFS_GROUP_BASE) begin
            read_init = c.group_filter[gi];
        end else if (o == `PRD_OFS_RX_WR_PAGE) begin
            read_init = c.rx_write_page;
        end else if (o >= `PRD_OFS_STATION_BASE) begin
            read_init = c.station_addr[si];
        end else begin
            read_init = `PRD_RESERVED_READ;
        end
    endfunction

    ////////////////////////////////////////////////////////////
    // read side of page 2: page 0 ring, transmit page, setup and mask bytes, plus host/net next pages and address counter
    function automatic logic [7:0] read_diag(
        input logic [3:0]         o,
        input prd_pkg::prd_cfg_t  c,
        input prd_pkg::prd_stat_t st
    );
        case (o)
            `PRD_OFS_RING_FIRST: read_diag = c.ring_first;
            `PRD_OFS_RING_LAST:  read_diag = c.ring_last;
            `PRD_OFS_HOST_NEXT:  read_diag = st.host_next;
            `PRD_OFS_TX_PAGE:    read_diag = c.tx_page;
            `PRD_OFS_NET_NEXT:   read_diag = st.net_next;
            `PRD_OFS_ACNT_HI:    read_diag = st.acnt[15:8];
            `PRD_OFS_ACNT_LO:    read_diag = st.acnt[7:0];
            `PRD_OFS_RX_SETUP:   read_diag = c.rx_setup;
            `PRD_OFS_TX_SETUP:   read_diag = c.tx_setup;
            `PRD_OFS_BUS_SETUP:  read_diag = c.bus_setup;
            `PRD_OFS_MASK:       read_diag = c.event_mask;
            default:             read_diag = `PRD_RESERVED_READ;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////
    // byte returned for a read
    function automatic logic [7:0] read_byte(
        input prd_pkg::prd_page_t p,
        input logic [3:0]         o,
        input logic [7:0]         c,
        input prd_pkg::prd_cfg_t  cf,
        input prd_pkg::prd_stat_t st
    );
        if (o == `PRD_OFS_CMD) begin
            read_byte = c;
        end else begin
            case (p)
                prd_pkg::PRD_PG_WORK: read_byte = read_work(o, cf, st);
                prd_pkg::PRD_PG_INIT: read_byte = read_init(o, cf);
                prd_pkg::PRD_PG_DIAG: read_byte = read_diag(o, cf, st);
                default:              read_byte = `PRD_RESERVED_READ;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////
    // current page and offset
    assign pg  = page_of(s_q.cmd);
    assign ofs = register_select_inputs;

    ////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d             = s_q;
        s_d.rd_valid    = 1'b0;
        s_d.fifo_rd     = 1'b0;
        s_d.ext.sel     = prd_pkg::PRD_EW_NONE;
        s_d.ext.data    = host_wdata;
        // transmit logic clears the send bit when done
        if (txp_done) begin
            s_d.cmd[`PRD_CMD_TXP] = 1'b0;
        end
        // read: byte captured, fifo port told on page 0 offset 6
        if (host_rd) begin
            s_d.rd_data  = read_byte(pg, ofs, s_q.cmd, s_q.cfg, stat);
            s_d.rd_valid = 1'b1;
            s_d.fifo_rd  = (pg == prd_pkg::PRD_PG_WORK)
                         && (ofs == `PRD_OFS_TX_LEN_HI);
        end
        // write: command in any page, even page 3
        if (host_wr && ofs == `PRD_OFS_CMD) begin
            s_d.cmd = host_wdata;
            // zero to send bit has no effect; set wins
            s_d.cmd[`PRD_CMD_TXP] = host_wdata[`PRD_CMD_TXP]
                                  | (s_q.cmd[`PRD_CMD_TXP] & ~txp_done);
        end else if (host_wr) begin
            case (pg)
                // page 0: configuration bytes; offset 7 passed to events owner
                prd_pkg::PRD_PG_WORK: begin
                    case (ofs)
                        `PRD_OFS_RING_FIRST: s_d.cfg.ring_first       = host_wdata;
                        `PRD_OFS_RING_LAST:  s_d.cfg.ring_last        = host_wdata;
                        `PRD_OFS_BOUNDARY:   s_d.cfg.boundary         = host_wdata;
                        `PRD_OFS_TX_PAGE:    s_d.cfg.tx_page          = host_wdata;
                        `PRD_OFS_TX_LEN_LO:  s_d.cfg.tx_len[7:0]      = host_wdata;
                        `PRD_OFS_TX_LEN_HI:  s_d.cfg.tx_len[15:8]     = host_wdata;
                        `PRD_OFS_EVENTS:     s_d.ext.sel = prd_pkg::PRD_EW_EVENTS;
                        `PRD_OFS_HDMA_LO:    s_d.cfg.hdma_start[7:0]  = host_wdata;
                        `PRD_OFS_HDMA_HI:    s_d.cfg.hdma_start[15:8] = host_wdata;
                        `PRD_OFS_HLEN_LO:    s_d.cfg.hdma_len[7:0]    = host_wdata;
                        `PRD_OFS_HLEN_HI:    s_d.cfg.hdma_len[15:8]   = host_wdata;
                        `PRD_OFS_RX_SETUP:   s_d.cfg.rx_setup         = host_wdata;
                        `PRD_OFS_TX_SETUP:   s_d.cfg.tx_setup         = host_wdata;
                        `PRD_OFS_BUS_SETUP:  s_d.cfg.bus_setup        = host_wdata;
                        `PRD_OFS_MASK:       s_d.cfg.event_mask       = host_wdata;
                        default:             ;
                    endcase
                end
                // page 1: station, write page, group filter
                prd_pkg::PRD_PG_INIT: begin
                    for (int i = 0; i < 6; i++) begin
                        if (ofs == 4'(i + 1)) begin
                            s_d.cfg.station_addr[i] = host_wdata;
                        end
                    end
                    if (ofs == `PRD_OFS_RX_WR_PAGE) begin
                        s_d.cfg.rx_write_page = host_wdata;
                    end
                    for (int j = 0; j < 8; j++) begin
                        if (ofs == 4'(j + 8)) begin
                            s_d.cfg.group_filter[j] = host_wdata;
                        end
                    end
                end
                // page 2: diagnostic loads passed to owners
                prd_pkg::PRD_PG_DIAG: begin
                    case (ofs)
                        `PRD_OFS_RING_FIRST: s_d.ext.sel = prd_pkg::PRD_EW_LDMA_LO;
                        `PRD_OFS_RING_LAST:  s_d.ext.sel = prd_pkg::PRD_EW_LDMA_HI;
                        `PRD_OFS_HOST_NEXT:  s_d.ext.sel = prd_pkg::PRD_EW_HOST_NEXT;
                        `PRD_OFS_NET_NEXT:   s_d.ext.sel = prd_pkg::PRD_EW_NET_NEXT;
                        `PRD_OFS_ACNT_HI:    s_d.ext.sel = prd_pkg::PRD_EW_ACNT_HI;
                        `PRD_OFS_ACNT_LO:    s_d.ext.sel = prd_pkg::PRD_EW_ACNT_LO;
                        default:             ;
                    endcase
                end
                // page 3: writes dropped to protect state
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q          <= '0;
            s_q.cmd      <= `PRD_CMD_RESET;
            s_q.rd_data  <= `PRD_RESERVED_READ;
            s_q.ext.sel  <= prd_pkg::PRD_EW_NONE;
            s_q.ext.data <= `PRD_CFG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////
    // outputs
    assign host_rdata       = s_q.rd_data;
    assign host_rdata_valid = s_q.rd_valid;
    assign command_control  = s_q.cmd;
    assign page             = pg;
    assign cfg              = s_q.cfg;
    assign ext_wr           = s_q.ext;
    assign fifo_peek_rd     = s_q.fifo_rd;

endmodule

/* test/prd_decoder_chk.sv */
////////////////////////////////////////////////////////////
// port-level checks of the paged decoder
module prd_decoder_chk (
    input wire logic                 clk,                    // system clock
    input wire logic                 rst,                    // sync reset
    input wire logic [3:0]           register_select_inputs, // offset
    input wire logic                 host_rd,                // read strobe
    input wire logic                 host_wr,                // write strobe
    input wire logic [7:0]           host_wdata,             // write byte
    input wire prd_pkg::prd_stat_t   stat,                   // live values
    input wire logic                 txp_done,               // send ended
    input wire logic [7:0]           host_rdata,             // read byte
    input wire logic                 host_rdata_valid,       // read ready
    input wire logic [7:0]           command_control,        // command byte
    input wire prd_pkg::prd_page_t   page,                   // current page
    input wire prd_pkg::prd_cfg_t    cfg,                    // stored bytes
    input wire prd_pkg::prd_ext_wr_t ext_wr,                 // passed-on write
    input wire logic                 fifo_peek_rd            // fifo read pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////
    // read or write taken at a given page code and offset
    sequence s_rd_pg(logic [1:0] g, logic [3:0] o);
        host_rd && command_control[7:6] == g && register_select_inputs == o;
    endsequence
    sequence s_wr_pg(logic [1:0] g, logic [3:0] o);
        host_wr && command_control[7:6] == g && register_select_inputs == o;
    endsequence

    ////////////////////////////////////////////////////////
    // every read answered next cycle, never unasked
    a_read_answer: assert property (host_rd |=> host_rdata_valid)
        else $error("read not answered");
    a_no_stray_valid: assert property (host_rdata_valid |-> $past(host_rd))
        else $error("read byte without request");
    a_page_code: assert property (2'(page) == command_control[7:6])
        else $error("page differs from command bits");
    a_cmd_write_any: assert property (host_wr && register_select_inputs == 4'h0
        |=> (command_control & 8'hE1) == ($past(host_wdata) & 8'hE1))
        else $error("command bits not loaded");
    a_cmd_read_back: assert property (host_rd && register_select_inputs == 4'h0
        |=> host_rdata == $past(command_control))
        else $error("command read wrong");
    a_work_status: assert property (s_rd_pg(2'h0, 4'h4) |=> host_rdata == $past(stat.tx_result))
        else $error("page 0 status read wrong");
    a_fifo_peek: assert property (s_rd_pg(2'h0, 4'h6) |=> fifo_peek_rd)
        else $error("fifo read pulse missing");
    a_diag_read: assert property (s_rd_pg(2'h2, 4'h1) |=> host_rdata == $past(cfg.ring_first))
        else $error("page 2 read wrong");
    a_station_store: assert property (s_wr_pg(2'h1, 4'h1) |=> cfg.station_addr[0] == $past(host_wdata))
        else $error("station byte not stored");
    a_locked_page: assert property (host_wr && command_control[7:6] == 2'h3 && register_select_inputs != 4'h0
        |=> $stable(cfg) && ext_wr.sel == prd_pkg::PRD_EW_NONE)
        else $error("write landed in page 3");
    a_reserved_read: assert property (s_rd_pg(2'h0, 4'hA) |=> host_rdata == 8'h00)
        else $error("reserved read not zero");
endmodule

bind prd_decoder prd_decoder_chk prd_decoder_chk_i (
    .clk(clk), .rst(rst), .register_select_inputs(register_select_inputs),
    .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata), .stat(stat),
    .txp_done(txp_done), .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid),
    .command_control(command_control), .page(page), .cfg(cfg), .ext_wr(ext_wr),
    .fifo_peek_rd(fifo_peek_rd)
);

/* test/prd_host.sv */
////////////////////////////////////////////////////////////
// host processor model on the register strobes
module prd_host (
    input  wire logic       clk,                    // system clock
    output logic            host_rd,                // read strobe
    output logic            host_wr,                // write strobe
    output logic [3:0]      register_select_inputs, // offset
    output logic [7:0]      host_wdata,             // write byte
    input  wire logic [7:0] host_rdata,             // read byte
    input  wire logic       host_rdata_valid        // read ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       misuse = 1'b0; // scenario may write while locked
    logic [1:0] pg_q   = 2'h0; // page the host believes is set

    // idle bus at time zero
    initial begin
        host_rd = 1'b0;
        host_wr = 1'b0;
        register_select_inputs = 4'hF;
        host_wdata = 8'hFF;
    end

    // one write; released lines never keep their value
    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        if (pg_q == 2'h3 && o != 4'h0 && !misuse) return;
        @(negedge clk);
        host_wr = 1'b1;
        register_select_inputs = o;
        host_wdata = d;
        @(negedge clk);
        host_wr = 1'b0;
        register_select_inputs = ~o;
        host_wdata = ~d;
        if (o == 4'h0) pg_q = d[7:6];
    endtask

    // one read; byte taken the cycle after the strobe
    task automatic rd(input logic [3:0] o, output logic [7:0] d, output logic v);
        @(negedge clk);
        host_rd = 1'b1;
        register_select_inputs = o;
        @(negedge clk);
        // valid stands only this cycle: take it before the next edge
        d = host_rdata;
        v = host_rdata_valid;
        host_rd = 1'b0;
        register_select_inputs = ~o;
    endtask
endmodule

/* test/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk, rst, txp_done, rd, wr, rv, v, fpr; // bus wires
    logic [3:0]           rs;                  // offset
    logic [7:0]           wd, hr, cc, rdata;   // bytes
    logic [7:0]           cmd, p0[16], p1[16]; // expected contents
    logic [159:0]         r;                   // random pool
    prd_pkg::prd_stat_t   stat;                // live values
    prd_pkg::prd_cfg_t    cfg, keep;           // stored bytes
    prd_pkg::prd_ext_wr_t ext_wr;              // passed-on write
    prd_pkg::prd_page_t   page;                // page out
    int                   n_fail = 0;
    int                   total_checks = 0;

    prd_decoder prd_decoder_i (.clk(clk), .rst(rst), .register_select_inputs(rs), .host_rd(rd),
        .host_wr(wr), .host_wdata(wd), .stat(stat), .txp_done(txp_done), .host_rdata(hr),
        .host_rdata_valid(rv), .command_control(cc), .page(page), .cfg(cfg), .ext_wr(ext_wr),
        .fifo_peek_rd(fpr));
    prd_host prd_host_i (.clk(clk), .host_rd(rd), .host_wr(wr), .register_select_inputs(rs),
        .host_wdata(wd), .host_rdata(hr), .host_rdata_valid(rv));

    ////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // count and report one comparison
    task automatic chk(logic c, string m);
        total_checks++;
        if (c !== 1'b1) begin
            n_fail++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // expected read byte per page code and offset
    function automatic logic [7:0] exp(logic [1:0] g, logic [3:0] o);
        logic [15:0][7:0] m0;
        logic [15:0][7:0] m2;
        m0 = {stat.missed_tally, stat.crc_tally, stat.align_tally, stat.rx_result, 16'h0000, stat.hdma_now,
            stat.event_flags, stat.fifo_peek, stat.collisions, stat.tx_result, p0[3], stat.ldma_now, cmd};
        m2 = {p0[15], p0[14], p0[13], p0[12], 32'h0000_0000, stat.acnt[7:0], stat.acnt[15:8],
            stat.net_next, p0[4], stat.host_next, p0[2], p0[1], cmd};
        if (o == 4'h0) return cmd;
        case (g)
            2'h0: return m0[o];
            2'h1: return p1[o];
            2'h2: return m2[o];
            default: return 8'h00;
        endcase
    endfunction

    // watchdog
    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(39));
        rst = 1'b1;
        txp_done = 1'b0;
        stat = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        cmd = 8'h01;
        chk(cc === 8'h01 && cfg === '0 && rv === 1'b0, "reset values");
        // page 0 configuration writes, 16-bit pairs
        for (int o = 1; o < 16; o++) begin
            p0[o] = 8'($urandom);
            prd_host_i.wr(4'(o), p0[o]);
            if (o == 7) chk(ext_wr.sel === prd_pkg::PRD_EW_EVENTS && ext_wr.data === p0[7], "event write");
        end
        chk(cfg.tx_len === {p0[6], p0[5]} && cfg.hdma_start === {p0[9], p0[8]}
            && cfg.hdma_len === {p0[11], p0[10]} && cfg.ring_first === p0[1], "page 0 bytes");
        // every page code, every offset read
        for (int g = 0; g < 4; g++) begin
            cmd = {2'(g), 6'($urandom) & 6'h3B};
            prd_host_i.wr(4'h0, cmd);
            chk(2'(page) === 2'(g) && cc === cmd, "page select");
            if (g == 1) for (int o = 1; o < 16; o++) begin
                p1[o] = 8'($urandom);
                prd_host_i.wr(4'(o), p1[o]);
            end
            if (g == 2) begin
                prd_host_i.wr(4'h3, 8'h3C);
                chk(ext_wr.sel === prd_pkg::PRD_EW_HOST_NEXT && ext_wr.data === 8'h3C, "diag write");
            end
            if (g == 3) begin
                keep = cfg;
                prd_host_i.misuse = 1'b1;
                prd_host_i.wr(4'h1, 8'h5A);
                chk(cfg === keep && ext_wr.sel === prd_pkg::PRD_EW_NONE, "locked write");
                prd_host_i.wr(4'hC, 8'hA5);
                chk(cfg === keep, "locked write");
            end
            r = {$urandom, $urandom, $urandom, $urandom, $urandom};
            stat = r[127:0];
            for (int o = 0; o < 16; o++) begin
                prd_host_i.rd(4'(o), rdata, v);
                chk(v === 1'b1 && rdata === exp(2'(g), 4'(o)), "read byte");
            end
        end
        // command bits writable while a send is pending
        prd_host_i.wr(4'h0, 8'h24);
        prd_host_i.wr(4'h0, 8'hE1);
        chk(cc === 8'hE5, "command bits");
        txp_done = 1'b1;
        @(negedge clk);
        txp_done = 1'b0;
        chk(cc === 8'hE1, "send bit clear");
        tally_and_finish();
    end
endmodule
